// ### design/gpio_defs.svh
// register offsets, field positions, reset values and sizes for the gpio port
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH
`define GPIO_PIN_COUNT     6
`define GPIO_OFF_SAMPLE    12'h000
`define GPIO_OFF_DIR       12'h004
`define GPIO_OFF_OUT       12'h008
`define GPIO_OFF_MCUCTL    12'h00c
`define GPIO_OFF_SENSE     12'h010
`define GPIO_OFF_EXTFLAG   12'h014
`define GPIO_PUD_BIT       6
`define GPIO_INT_PIN       2
`define GPIO_RST_DIR       6'h00
`define GPIO_RST_OUT       6'h00
`define GPIO_RST_MCUCTL    8'h00
`define GPIO_ADDR_BITS     12
`endif

// ### design/gpio_pkg.sv
// types shared by the gpio port files
package gpio_pkg;
    typedef enum logic [1:0] {
        GPIO_SENSE_LOW  = 2'b00,
        GPIO_SENSE_ANY  = 2'b01,
        GPIO_SENSE_FALL = 2'b10,
        GPIO_SENSE_RISE = 2'b11
    } gpio_sense_type;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [11:0] addr;
    } gpio_req_type;

    typedef enum logic [0:0] {
        GPIO_BUS_IDLE = 1'b0,
        GPIO_BUS_DATA = 1'b1
    } gpio_bus_state_type;
endpackage : gpio_pkg

// ### design/gpio_sync.sv
// per-pin input synchroniser: falling-edge flop then rising-edge flop
`timescale 1ns/1ps
module gpio_sync
    import gpio_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic [5:0] pad_in,
    output logic      [5:0] sample_out
);
    logic [5:0] hold_ff;
    logic [5:0] sample_ff;
    logic [5:0] nxt_hold;
    logic [5:0] nxt_sample;

    // first stage takes the pin only at the falling edge, the value a clock-high latch would hold from that edge
    // (a true latch would race the rising-edge stage in the same time step)
    always_comb begin
        nxt_hold   = pad_in; // [R12]
        nxt_sample = hold_ff; // [R12] [R13]
    end

    // hold stage closes at the falling edge
    always_ff @(negedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_ff <= 6'h00;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    // sample stage captures the held value at the rising edge
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sample_ff <= 6'h00;
        end else begin
            sample_ff <= nxt_sample;
        end
    end

    assign sample_out = sample_ff;
endmodule : gpio_sync

// ### design/gpio_extint.sv
// external interrupt edge detector on the synchronised interrupt pin; low-level sense keeps the flag clear
`timescale 1ns/1ps
module gpio_extint
    import gpio_pkg::*;
(
    input  wire logic           mclk_in,
    input  wire logic           rst_in,
    input  wire logic           pin_in,
    input  gpio_sense_type      sense_in,
    input  wire logic           clear_in,
    output logic                flag_out
);
    logic prev_ff;
    logic flag_ff;
    logic nxt_prev;
    logic nxt_flag;
    logic hit;

    // detect the selected change; a new event beats a same-cycle clear
    always_comb begin
        nxt_prev = pin_in;
        unique case (sense_in)
            GPIO_SENSE_LOW:  hit = 1'b0;
            GPIO_SENSE_ANY:  hit = pin_in ^ prev_ff;
            GPIO_SENSE_FALL: hit = prev_ff & ~pin_in;
            GPIO_SENSE_RISE: hit = ~prev_ff & pin_in;
        endcase
        nxt_flag = flag_ff;
        if (clear_in || sense_in == GPIO_SENSE_LOW) begin
            nxt_flag = 1'b0;
        end
        if (hit) begin
            nxt_flag = 1'b1; // [R17]
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_ff <= 1'b0;
            flag_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            flag_ff <= nxt_flag;
        end
    end

    assign flag_out = flag_ff;
endmodule : gpio_extint

// ### design/gpio_port.sv
// general digital i/o port with ahb-lite register access
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "gpio_defs.svh"

// How it works
// [R1] each pin has a direction bit, an output/pull-up bit and a sample bit
// [R2] direction one enables the output driver; zero makes the pin an input
// [R3] input with output bit one enables pull-up unless global disable set
// [R4] pull-up is off when output bit is zero or pin is an output
// [R5] global pull-up disable turns off every pull-up
// [R6] an output pin drives the value of its output bit
// [R7] reset tri-states all pins asynchronously and turns pull-ups off
// [R8] writing one to a sample bit inverts the output bit
// [R9] software passes through an intermediate state between tri-state and high
// [R10] software passes through tri-state or high between pull-up and low
// [R11] sample register reads the synchronised pin level in any direction
// [R12] pins pass a clock-high latch then a rising-edge flop
// [R13] pin change shows in the sample after half to one and a half clocks
// [R14] written value reaches the sample register one clock later
// [R15] power-down sleep clamps the digital input to ground
// [R16] the clamp is bypassed for a pin with its external interrupt enabled
// [R17] removing the clamp from a high pin sets the external interrupt flag; the code sets it only with any-change or rising sense selected
// [R18] unused pins should be held at a defined level by software
// [R19] sample register writes only toggle; direction and output are read/write
// [R20] global pull-up disable is bit 6 of the control register, reset zero
// [R21] reset clears direction and output bits
// [R22] register writes touch only the addressed bits
module gpio_port
    import gpio_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [5:0]  pad_in,
    output logic      [5:0]  pad_out,
    output logic      [5:0]  pad_oe_n_out,
    output logic      [5:0]  pullup_en_out,
    input  wire logic        sleep_pd_in,
    input  wire logic        ext_int_en_in,
    output logic             ext_int_flag_out
);
    // register file state
    logic [5:0]     dir_ff;
    logic [5:0]     out_ff;
    logic [7:0]     mcuctl_ff;
    gpio_sense_type sense_ff;
    logic [5:0]     nxt_dir;
    logic [5:0]     nxt_out;
    logic [7:0]     nxt_mcuctl;
    gpio_sense_type nxt_sense;

    // bus state
    gpio_bus_state_type bus_ff;
    gpio_bus_state_type nxt_bus;
    gpio_req_type       req_ff;
    gpio_req_type       nxt_req;
    logic [31:0]        rdata_ff;
    logic [31:0]        nxt_rdata;

    // pin outputs
    logic [5:0] pad_ff;
    logic [5:0] oe_n_ff;
    logic [5:0] pu_ff;
    logic [5:0] nxt_pad;
    logic [5:0] nxt_oe_n;
    logic [5:0] nxt_pu;

    // sleep clamp, sync and interrupt
    logic [1:0] ctl_s1_ff;
    logic [1:0] ctl_s2_ff;
    logic [5:0] pad_gated;
    logic [5:0] sample;
    logic       flag_clr;
    logic       ext_flag;
    logic       wr_data;
    logic       rd_addr;

    // two-flop sync of sleep and interrupt enable levels from outside
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_s1_ff <= 2'h0;
            ctl_s2_ff <= 2'h0;
        end else begin
            ctl_s1_ff <= {sleep_pd_in, ext_int_en_in};
            ctl_s2_ff <= ctl_s1_ff;
        end
    end

    // clamp inputs in power-down, except the enabled interrupt pin
    genvar g;
    generate
        for (g = 0; g < `GPIO_PIN_COUNT; g = g + 1) begin : g_clamp
            if (g == `GPIO_INT_PIN) begin : g_int
                assign pad_gated[g] = pad_in[g] & ~(ctl_s2_ff[1] & ~ctl_s2_ff[0]); // [R15] [R16]
            end else begin : g_norm
                assign pad_gated[g] = pad_in[g] & ~ctl_s2_ff[1]; // [R15]
            end
        end
    endgenerate

    // falling-edge flop plus rising-edge flop synchroniser feeding the sample register
    gpio_sync u_sync (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .pad_in     (pad_gated),
        .sample_out (sample)
    );

    // external interrupt on the sampled interrupt pin
    gpio_extint u_extint (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .pin_in   (sample[`GPIO_INT_PIN]),
        .sense_in (sense_ff),
        .clear_in (flag_clr),
        .flag_out (ext_flag)
    );

    // ahb-lite address phase capture, zero wait states
    always_comb begin
        nxt_req = req_ff;
        nxt_bus = GPIO_BUS_IDLE;
        if (hready) begin
            nxt_req.sel   = hsel & htrans[1];
            nxt_req.write = hwrite;
            nxt_req.addr  = haddr[11:0];
            if (hsel && htrans[1]) begin
                nxt_bus = GPIO_BUS_DATA;
            end
        end else begin
            nxt_bus = bus_ff;
        end
    end

    assign wr_data = req_ff.sel & req_ff.write;
    assign rd_addr = hready & hsel & htrans[1] & ~hwrite;
    assign flag_clr = wr_data && req_ff.addr == `GPIO_OFF_EXTFLAG && hwdata[6];

    // register writes and read data
    always_comb begin
        nxt_dir    = dir_ff;
        nxt_out    = out_ff;
        nxt_mcuctl = mcuctl_ff;
        nxt_sense  = sense_ff;
        nxt_rdata  = 32'h00000000;
        if (wr_data) begin
            unique case (req_ff.addr)
                `GPIO_OFF_SAMPLE: nxt_out = out_ff ^ hwdata[5:0]; // [R8] [R19] [R22]
                `GPIO_OFF_DIR:    nxt_dir = hwdata[5:0]; // [R1] [R22]
                `GPIO_OFF_OUT:    nxt_out = hwdata[5:0]; // [R1] [R22]
                `GPIO_OFF_MCUCTL: begin
                    nxt_mcuctl = {1'b0, hwdata[6:5], 5'h00} | {6'h00, hwdata[1:0]}; // [R20]
                    nxt_sense  = gpio_sense_type'(hwdata[1:0]);
                end
                default: nxt_out = nxt_out;
            endcase
        end
        if (rd_addr) begin
            unique case (haddr[11:0])
                `GPIO_OFF_SAMPLE:  nxt_rdata = {26'h0000000, sample}; // [R11]
                `GPIO_OFF_DIR:     nxt_rdata = {26'h0000000, nxt_dir};
                `GPIO_OFF_OUT:     nxt_rdata = {26'h0000000, nxt_out};
                `GPIO_OFF_MCUCTL:  nxt_rdata = {24'h000000, nxt_mcuctl};
                `GPIO_OFF_EXTFLAG: nxt_rdata = {25'h0000000, ext_flag, 6'h00};
                default:           nxt_rdata = 32'h00000000;
            endcase
        end
    end

    // pin drive: direction enables driver, output bit sets level or pull-up
    always_comb begin
        nxt_oe_n = ~nxt_dir; // [R2]
        nxt_pad  = nxt_out & nxt_dir; // [R6]
        nxt_pu   = ~nxt_dir & nxt_out & {6{~nxt_mcuctl[`GPIO_PUD_BIT]}}; // [R3] [R4] [R5]
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            dir_ff    <= `GPIO_RST_DIR; // [R21]
            out_ff    <= `GPIO_RST_OUT; // [R21]
            mcuctl_ff <= `GPIO_RST_MCUCTL; // [R20]
            sense_ff  <= GPIO_SENSE_LOW;
            bus_ff    <= GPIO_BUS_IDLE;
            req_ff    <= '0;
            rdata_ff  <= 32'h00000000;
            pad_ff    <= 6'h00;
            oe_n_ff   <= 6'h3f; // [R7]
            pu_ff     <= 6'h00; // [R7]
        end else begin
            dir_ff    <= nxt_dir;
            out_ff    <= nxt_out;
            mcuctl_ff <= nxt_mcuctl;
            sense_ff  <= nxt_sense;
            bus_ff    <= nxt_bus;
            req_ff    <= nxt_req;
            rdata_ff  <= nxt_rdata;
            pad_ff    <= nxt_pad; // [R14]
            oe_n_ff   <= nxt_oe_n;
            pu_ff     <= nxt_pu;
        end
    end

    assign hrdata           = rdata_ff;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign pad_out          = pad_ff;
    assign pad_oe_n_out     = oe_n_ff;
    assign pullup_en_out    = pu_ff;
    assign ext_int_flag_out = ext_flag;
endmodule : gpio_port

// ### dv/gpio_port_assertions.sv
// concurrent checks on the gpio port outputs
`timescale 1ns/1ps
module gpio_port_chk (
    input wire logic        mclk_in,
    input wire logic        rst_in,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [5:0]  pad_out,
    input wire logic [5:0]  pad_oe_n_out,
    input wire logic [5:0]  pullup_en_out,
    input wire logic        ext_int_flag_out
);
    logic [3:0] wr_hist_ff;
    logic [3:0] nxt_wr_hist;
    // accepted write address phases over the last four edges
    always_comb begin
        nxt_wr_hist = {wr_hist_ff[2:0], hsel & htrans[1] & hready & hwrite};
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_hist_ff <= 4'h0;
        end else begin
            wr_hist_ff <= nxt_wr_hist;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    AST_RST_TRI: assert property (disable iff (1'b0) rst_in |-> pad_oe_n_out == 6'h3f && pullup_en_out == 6'h00)
        else $error("pins not released in reset");
    AST_PU_NOT_OUT: assert property ((pullup_en_out & ~pad_oe_n_out) == 6'h00)
        else $error("pull-up on a driven pin");
    AST_OE_HOLD: assert property (wr_hist_ff == 4'h0 |-> $stable(pad_oe_n_out))
        else $error("direction moved without a write");
    AST_DRV_CAUSE: assert property ($changed(pad_out) |-> wr_hist_ff != 4'h0)
        else $error("drive level moved without a write");
    AST_PU_CAUSE: assert property ($changed(pullup_en_out) |-> |wr_hist_ff)
        else $error("pull-up moved without a write");
    AST_FLAG_CLR: assert property ($fell(ext_int_flag_out) |-> $past(|wr_hist_ff))
        else $error("flag cleared without a write");
    AST_HR_UPPER: assert property (hrdata[31:7] == 25'h0)
        else $error("unused read bits set");
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
endmodule : gpio_port_chk
bind gpio_port gpio_port_chk i_chk (.mclk_in, .rst_in, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .pad_out, .pad_oe_n_out, .pullup_en_out, .ext_int_flag_out);

// ### dv/gpio_board.sv
// board model: resolves each pad from port driver, bench drivers and pull-ups
`timescale 1ns/1ps
module gpio_board (
    input  wire logic       mclk_in,
    input  wire logic [5:0] drv_in,
    input  wire logic [5:0] oe_n_in,
    input  wire logic [5:0] pu_in,
    input  wire logic [5:0] ext_en_in,
    input  wire logic [5:0] ext_val_in,
    output logic      [5:0] level_out
);
    logic [5:0] float_ff = 6'h15;
    // an undriven pad wanders each cycle so no stale level can be relied on
    always_ff @(posedge mclk_in) begin
        float_ff <= ~float_ff;
    end
    // port driver first, then a held external level, then the pull-up
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!oe_n_in[i]) begin
                level_out[i] = drv_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pu_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = float_ff[i];
            end
        end
    end
endmodule : gpio_board

// ### dv/tb_general_digital_io_port.sv
// self-checking bench for the gpio port
`timescale 1ns/1ps
`include "gpio_defs.svh"
module tb_general_digital_io_port;
    logic        mclk_in = 1'b0;
    logic        rst_in  = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic        sleep   = 1'b0;
    logic        int_en  = 1'b0;
    logic [5:0]  ext_val = 6'h24;
    logic [31:0] hrdata, rd;
    logic        rdy, hresp, flag;
    logic [5:0]  lvl, drv, oe_n, pu;
    int          failures  = 0;
    int          cmp_count = 0;
    always #50 mclk_in = ~mclk_in;
    gpio_port i_dut (.mclk_in, .rst_in, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(rdy),
        .hrdata, .hreadyout(rdy), .hresp, .pad_in(lvl), .pad_out(drv), .pad_oe_n_out(oe_n),
        .pullup_en_out(pu), .sleep_pd_in(sleep), .ext_int_en_in(int_en), .ext_int_flag_out(flag));
    gpio_board i_board (.mclk_in, .drv_in(drv), .oe_n_in(oe_n), .pu_in(pu), .ext_en_in(6'h2c),
        .ext_val_in(ext_val), .level_out(lvl));
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        cmp_count++;
        if ((got & msk) !== (exp & msk)) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // waits for hready sampled high at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: bus hung", $time);
            close_out();
        end
    endtask : wait_rdy
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp, msk);
    endtask : rdc
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cyc
    // main sequence
    initial begin
        rst_in <= 1'b1;
        cyc(20);
        rst_in <= 1'b0;
        cyc(1);
        chk(32'(oe_n), 32'h3f, 32'h3f);
        chk(32'(pu), 32'h0, 32'h3f);
        rdc(`GPIO_OFF_DIR, 32'h0, '1);
        rdc(`GPIO_OFF_OUT, 32'h0, '1);
        rdc(`GPIO_OFF_MCUCTL, 32'h0, '1);
        rdc(12'h018, 32'h0, '1);
        xfer(`GPIO_OFF_OUT, 1'b1, 32'h13);
        cyc(2);
        chk(32'(pu), 32'h13, 32'h3f);
        xfer(`GPIO_OFF_DIR, 1'b1, 32'h03);
        cyc(2);
        chk(32'(oe_n), 32'h3c, 32'h3f);
        chk(32'(drv), 32'h03, 32'h03);
        chk(32'(pu), 32'h10, 32'h3f);
        rdc(`GPIO_OFF_SAMPLE, 32'h37, '1);
        // a back-to-back read still sees the old pin, the read right after it sees the new one
        xfer(`GPIO_OFF_OUT, 1'b1, 32'h12);
        rdc(`GPIO_OFF_SAMPLE, 32'h01, 32'h01);
        rdc(`GPIO_OFF_SAMPLE, 32'h00, 32'h01);
        xfer(`GPIO_OFF_OUT, 1'b1, 32'h13);
        xfer(`GPIO_OFF_MCUCTL, 1'b1, 32'h40);
        cyc(2);
        chk(32'(pu), 32'h0, 32'h3f);
        rdc(`GPIO_OFF_MCUCTL, 32'h40, '1);
        xfer(`GPIO_OFF_MCUCTL, 1'b1, 32'h01);
        xfer(`GPIO_OFF_SAMPLE, 1'b1, 32'h21);
        rdc(`GPIO_OFF_OUT, 32'h32, '1);
        rdc(`GPIO_OFF_DIR, 32'h03, '1);
        chk(32'(drv), 32'h02, 32'h03);
        ext_val <= 6'h04;
        cyc(2);
        rdc(`GPIO_OFF_SAMPLE, 32'h16, '1);
        int_en <= 1'b1;
        sleep  <= 1'b1;
        cyc(4);
        rdc(`GPIO_OFF_SAMPLE, 32'h04, '1);
        int_en <= 1'b0;
        cyc(4);
        rdc(`GPIO_OFF_SAMPLE, 32'h0, '1);
        chk(32'(flag), 32'h1, 32'h1);
        xfer(`GPIO_OFF_EXTFLAG, 1'b1, 32'h40);
        cyc(3);
        chk(32'(flag), 32'h0, 32'h1);
        sleep <= 1'b0;
        cyc(6);
        chk(32'(flag), 32'h1, 32'h1);
        rdc(`GPIO_OFF_EXTFLAG, 32'h40, 32'h40);
        // falling, rising and low-level sensing on the interrupt pin
        xfer(`GPIO_OFF_MCUCTL, 1'b1, 32'h02);
        xfer(`GPIO_OFF_EXTFLAG, 1'b1, 32'h40);
        ext_val <= 6'h00;
        cyc(4);
        chk(32'(flag), 32'h1, 32'h1);
        xfer(`GPIO_OFF_MCUCTL, 1'b1, 32'h03);
        xfer(`GPIO_OFF_EXTFLAG, 1'b1, 32'h40);
        cyc(2);
        chk(32'(flag), 32'h0, 32'h1);
        ext_val <= 6'h04;
        cyc(4);
        chk(32'(flag), 32'h1, 32'h1);
        xfer(`GPIO_OFF_MCUCTL, 1'b1, 32'h00);
        cyc(2);
        rdc(`GPIO_OFF_EXTFLAG, 32'h00, 32'h40);
        @(negedge mclk_in);
        rst_in <= 1'b1;
        #1;
        chk(32'(oe_n), 32'h3f, 32'h3f);
        chk(32'(pu), 32'h0, 32'h3f);
        close_out();
    end
endmodule : tb_general_digital_io_port
